// ---- logic/program_memory_table_read.v ----
// program store, table read path, serial programming port and data memory map
//
// Behaviour
// RULE1 - program store holds 2K words of 15 bits each
// RULE2 - fetches use the program counter; table reads use the table pointer
// RULE3 - any reset loads program counter with word 000H
// RULE4 - table read writes low byte of fetched word into chosen data register; the code writes it only when that register is at 80H to FFH
// RULE5 - table read writes upper part of fetched word into table high latch
// RULE6 - table high latch is read-only; only table reads change it
// RULE7 - table instructions take two instruction cycles
// RULE8 - software avoids table reads in both main flow and interrupt handlers
// RULE9 - last 256-word page begins at word 0700H
// RULE10 - current-page table read uses pointer plus current program counter page
// RULE11 - programming moves data serially over one two-way line with external clock
// RULE12 - no other driver on programming lines while programming
// RULE13 - debug link has two-way data line and clock input line
// RULE14 - in debug use, functions sharing the debug lines have no effect
// RULE15 - debug lines also serve as serial programming lines
// RULE16 - data memory is volatile 8-bit RAM starting at 00H
// RULE17 - data addresses 00H to 7FH decode to special function area
// RULE18 - data addresses 80H to FFH are readable and writable general RAM
// RULE19 - some special locations are write protected, others read-write
// RULE20 - a page spans 256 words; pointer byte selects word within page
// RULE21 - reads of unused special addresses return 00H
// RULE22 - last-page table read uses pointer within last page regardless of counter
// RULE23 - extra table cycle uses the store port, then fetching resumes
`include "prog_mem_map.vh"
`timescale 1ns/1ps
`default_nettype none

module program_memory_table_read #(
	parameter PM_DEPTH = `PM_DEPTH
) (
	// clock, reset, enable
	input  wire        CLK_IN,
	input  wire        RESET_IN,
	input  wire        CLK_EN_IN,
	// core fetch and table request
	input  wire        PC_ADVANCE_IN,
	input  wire        PC_LOAD_IN,
	input  wire [10:0] PC_LOAD_VALUE_IN,
	input  wire        TABLE_READ_IN,
	input  wire        TABLE_LAST_PAGE_IN,
	input  wire [7:0]  TABLE_DEST_IN,
	// core data memory port
	input  wire        DM_WRITE_IN,
	input  wire        DM_READ_IN,
	input  wire [7:0]  DM_ADDR_IN,
	input  wire [7:0]  DM_WDATA_IN,
	// special function area, implemented outside
	input  wire [7:0]  SFR_RDATA_IN,
	input  wire        SFR_PRESENT_IN,
	input  wire        SFR_PROTECTED_IN,
	// serial programming / debug lines
	input  wire        DEBUG_MODE_IN,
	input  wire        PROG_ENABLE_IN,
	input  wire        PROG_CLOCK_LINE_IN,
	input  wire        PROG_DATA_LINE_IN,
	output reg         PROG_DATA_LINE_OUT,
	output reg         PROG_DATA_LINE_OE_N_OUT,
	output reg         SHARED_FUNC_ENABLE_OUT,
	// outputs to core
	output reg  [10:0] PC_OUT,
	output reg  [14:0] INSTR_OUT,
	output reg         INSTR_VALID_OUT,
	output reg         TABLE_BUSY_OUT,
	output reg  [7:0]  DM_RDATA_OUT,
	output reg         SFR_WRITE_OUT,
	output reg  [6:0]  TABLE_HIGH_LATCH_OUT,
	output reg  [7:0]  TABLE_POINTER_OUT
);

	localparam ST_FETCH = 2'b01;
	localparam ST_TABLE = 2'b10;

	reg [14:0] prog_store [0:PM_DEPTH-1];
	reg [7:0]  gpr_ram [0:`DM_GPR_DEPTH-1];
	reg [1:0]  state_reg;
	reg [10:0] table_addr_reg;
	reg [7:0]  table_dest_reg;
	reg        prog_clk_prev_reg;
	reg [27:0] prog_shift_reg;
	reg [4:0]  prog_count_reg;
	reg [10:0] prog_addr_reg;
	reg [14:0] prog_out_reg;
	reg        prog_drive_reg;

	// decode helpers: general area test and sfr test used in read and write paths
	function is_gpr;
		input [7:0] a;
		is_gpr = a[7]; // see RULE18
	endfunction

	function is_sfr;
		input [7:0] a;
		is_sfr = ~a[7]; // see RULE17
	endfunction

	wire       prog_active = PROG_ENABLE_IN;
	wire       prog_rise = PROG_CLOCK_LINE_IN & ~prog_clk_prev_reg;
	// at the last rising clock the first 27 frame bits sit in [26:0]
	wire [1:0] prog_cmd = prog_shift_reg[26:25];
	wire [14:0] fetched_word = prog_store[PC_OUT];
	wire [14:0] table_word = prog_store[table_addr_reg];
	// current page keeps counter high bits; last page forces page 7
	wire [2:0] table_page = TABLE_LAST_PAGE_IN ? `PM_LAST_PAGE : PC_OUT[10:8]; // see RULE9 see RULE22 see RULE10
	wire       ptr_write = CLK_EN_IN & DM_WRITE_IN & (DM_ADDR_IN == `SFR_TBLP_ADDR);

	////////////////////////////////////////////////////////////////////////////////
	// fetch and table read sequencer
	always @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			PC_OUT          <= `PM_RESET_VECTOR; // see RULE3
			state_reg       <= ST_FETCH;
			INSTR_OUT       <= 15'h0000;
			INSTR_VALID_OUT <= 1'b0;
			TABLE_BUSY_OUT  <= 1'b0;
			table_addr_reg  <= 11'h000;
			table_dest_reg  <= 8'h00;
			TABLE_HIGH_LATCH_OUT <= 7'h00;
			TABLE_POINTER_OUT    <= 8'h00;
		end else if (CLK_EN_IN) begin
			if (ptr_write)
				TABLE_POINTER_OUT <= DM_WDATA_IN; // see RULE20
			case (state_reg)
			ST_FETCH: begin
				// programming owns the store port; hold the core off
				INSTR_VALID_OUT <= ~prog_active;
				INSTR_OUT       <= fetched_word; // see RULE2
				if (!prog_active && TABLE_READ_IN) begin
					table_addr_reg <= {table_page, TABLE_POINTER_OUT}; // see RULE2
					table_dest_reg <= TABLE_DEST_IN;
					TABLE_BUSY_OUT <= 1'b1;
					INSTR_VALID_OUT <= 1'b0;
					state_reg      <= ST_TABLE; // see RULE7
				end else if (!prog_active && PC_LOAD_IN)
					PC_OUT <= PC_LOAD_VALUE_IN;
				else if (!prog_active && PC_ADVANCE_IN)
					PC_OUT <= PC_OUT + 11'h001;
			end
			ST_TABLE: begin
				// second cycle: store port serves the table, then fetching resumes
				TABLE_HIGH_LATCH_OUT <= table_word[14:8]; // see RULE5 see RULE6 see RULE23
				TABLE_BUSY_OUT       <= 1'b0;
				state_reg            <= ST_FETCH; // see RULE23
			end
			default: state_reg <= ST_FETCH;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// general RAM: no reset, volatile contents; table low byte enters here too
	always @(posedge CLK_IN) begin
		if (CLK_EN_IN && state_reg == ST_TABLE && is_gpr(table_dest_reg))
			gpr_ram[table_dest_reg[6:0]] <= table_word[7:0]; // see RULE4 see RULE16
		else if (CLK_EN_IN && DM_WRITE_IN && is_gpr(DM_ADDR_IN))
			gpr_ram[DM_ADDR_IN[6:0]] <= DM_WDATA_IN; // see RULE18
	end

	////////////////////////////////////////////////////////////////////////////////
	// data read path and sfr write strobe
	always @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			DM_RDATA_OUT  <= `DM_UNUSED_VALUE;
			SFR_WRITE_OUT <= 1'b0;
		end else if (CLK_EN_IN) begin
			// latch address and pointer are handled here; protected ones drop writes
			SFR_WRITE_OUT <= DM_WRITE_IN & is_sfr(DM_ADDR_IN) & ~SFR_PROTECTED_IN
				& (DM_ADDR_IN != `SFR_TABLE_HIGH_LATCH_ADDR) & (DM_ADDR_IN != `SFR_TBLP_ADDR); // see RULE19 see RULE6
			if (DM_READ_IN) begin
				if (is_gpr(DM_ADDR_IN))
					DM_RDATA_OUT <= gpr_ram[DM_ADDR_IN[6:0]];
				else if (DM_ADDR_IN == `SFR_TABLE_HIGH_LATCH_ADDR)
					DM_RDATA_OUT <= {1'b0, TABLE_HIGH_LATCH_OUT};
				else if (DM_ADDR_IN == `SFR_TBLP_ADDR)
					DM_RDATA_OUT <= TABLE_POINTER_OUT;
				else if (SFR_PRESENT_IN)
					DM_RDATA_OUT <= SFR_RDATA_IN;
				else
					DM_RDATA_OUT <= `DM_UNUSED_VALUE; // see RULE21
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// serial programming: 28-bit frames, 2-bit command, 11-bit address, 15-bit data,
	// sampled on rising edges of the programmer's clock line
	always @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			prog_clk_prev_reg <= 1'b0;
			prog_shift_reg    <= 28'h000_0000;
			prog_count_reg    <= 5'h00;
			prog_addr_reg     <= 11'h000;
			prog_out_reg      <= 15'h0000;
			prog_drive_reg    <= 1'b0;
			PROG_DATA_LINE_OUT      <= 1'b0;
			PROG_DATA_LINE_OE_N_OUT <= 1'b1;
			SHARED_FUNC_ENABLE_OUT  <= 1'b1;
		end else if (CLK_EN_IN) begin
			prog_clk_prev_reg <= PROG_CLOCK_LINE_IN;
			// in debug use or programming, shared pin functions are cut off
			SHARED_FUNC_ENABLE_OUT <= ~(DEBUG_MODE_IN | prog_active); // see RULE14 see RULE15
			if (!prog_active) begin
				prog_count_reg <= 5'h00;
				prog_drive_reg <= 1'b0;
				PROG_DATA_LINE_OE_N_OUT <= 1'b1;
			end else if (prog_rise && prog_drive_reg) begin
				// upload: shift read word out msb first, one bit per clock
				PROG_DATA_LINE_OUT <= prog_out_reg[14]; // see RULE11 see RULE13
				prog_out_reg       <= {prog_out_reg[13:0], 1'b0};
				prog_count_reg     <= prog_count_reg + 5'h01;
				if (prog_count_reg == 5'd14) begin
					prog_drive_reg <= 1'b0;
					prog_count_reg <= 5'h00;
				end
				PROG_DATA_LINE_OE_N_OUT <= 1'b0;
			end else if (prog_rise) begin
				PROG_DATA_LINE_OE_N_OUT <= 1'b1; // release; we rely on a sole driver, see RULE12
				prog_shift_reg <= {prog_shift_reg[26:0], PROG_DATA_LINE_IN}; // see RULE11
				prog_count_reg <= prog_count_reg + 5'h01;
				if (prog_count_reg == 5'd27) begin
					prog_count_reg <= 5'h00;
					prog_addr_reg  <= prog_shift_reg[24:14];
					if (prog_cmd == `PROG_CMD_READ) begin
						prog_out_reg   <= prog_store[prog_shift_reg[24:14]];
						prog_drive_reg <= 1'b1;
					end
				end
			end
		end
	end

	// program store write port, only from the programmer at frame end
	always @(posedge CLK_IN) begin
		if (CLK_EN_IN && prog_active && prog_rise && !prog_drive_reg && prog_count_reg == 5'd27
			&& prog_shift_reg[26:25] == `PROG_CMD_WRITE)
			prog_store[prog_shift_reg[24:14]] <= {prog_shift_reg[13:0], PROG_DATA_LINE_IN}; // see RULE1
	end

endmodule // program_memory_table_read

`default_nettype wire

// ---- logic/prog_mem_map.vh ----
// constants for the program store, table read path and data memory map
`ifndef PROG_MEM_MAP_VH
`define PROG_MEM_MAP_VH

`define PM_DEPTH          2048
`define PM_ADDR_W         11
`define PM_WORD_W         15
`define PM_RESET_VECTOR   11'h000
`define PM_LAST_PAGE      3'h7
`define PM_LAST_PAGE_BASE 11'h700
`define PM_PAGE_WORDS     256
`define DM_ADDR_W         8
`define DM_WORD_W         8
`define DM_SFR_FIRST      8'h00
`define DM_SFR_LAST       8'h7F
`define DM_GPR_FIRST      8'h80
`define DM_GPR_LAST       8'hFF
`define DM_GPR_DEPTH      128
`define DM_UNUSED_VALUE   8'h00
`define SFR_TBLP_ADDR     8'h07
`define SFR_TABLE_HIGH_LATCH_ADDR     8'h08
`define TBL_HIGH_W        7
`define PROG_CMD_W        2
`define PROG_CMD_NONE     2'h0
`define PROG_CMD_ADDR     2'h1
`define PROG_CMD_WRITE    2'h2
`define PROG_CMD_READ     2'h3

`endif

// ---- dv/prog_table_monitor.sv ----
// assertions on the program store and table read ports
`timescale 1ns/1ps
`default_nettype none
module prog_table_monitor (
	// clock, reset and core inputs, plus table pointer and read data outputs
	input wire logic        CLK_IN, RESET_IN, CLK_EN_IN, TABLE_READ_IN, PROG_ENABLE_IN, DEBUG_MODE_IN,
	input wire logic        DM_WRITE_IN, DM_READ_IN, SFR_PRESENT_IN,
	input wire logic [7:0]  DM_ADDR_IN, DM_WDATA_IN, TABLE_POINTER_OUT, DM_RDATA_OUT,
	// observed outputs
	input wire logic        PROG_DATA_LINE_OE_N_OUT, SHARED_FUNC_ENABLE_OUT, TABLE_BUSY_OUT,
	input wire logic [10:0] PC_OUT,
	input wire logic [6:0]  TABLE_HIGH_LATCH_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	// core requests only count while running and not programming
	wire go = CLK_EN_IN && !PROG_ENABLE_IN;
	property p_two; go && TABLE_READ_IN && !TABLE_BUSY_OUT |=> TABLE_BUSY_OUT ##1 !TABLE_BUSY_OUT; endproperty
	a_two: assert property (p_two) else $error("table read length wrong");
	property p_pc; TABLE_BUSY_OUT |=> $stable(PC_OUT); endproperty
	a_pc: assert property (p_pc) else $error("pc moved in table read");
	property p_latch; !TABLE_BUSY_OUT |=> $stable(TABLE_HIGH_LATCH_OUT); endproperty
	a_latch: assert property (p_latch) else $error("high latch changed");
	property p_vec; $fell(RESET_IN) |-> PC_OUT == 11'h000; endproperty
	a_vec: assert property (p_vec) else $error("pc not at vector");
	property p_rel; !PROG_ENABLE_IN |-> ##[0:1] PROG_DATA_LINE_OE_N_OUT; endproperty
	a_rel: assert property (p_rel) else $error("serial line driven");
	property p_shr; DEBUG_MODE_IN || PROG_ENABLE_IN |-> ##[0:1] !SHARED_FUNC_ENABLE_OUT; endproperty
	a_shr: assert property (p_shr) else $error("shared function active");
	property p_ptr; go && DM_WRITE_IN && DM_ADDR_IN == 8'h07 |=> TABLE_POINTER_OUT == $past(DM_WDATA_IN); endproperty
	a_ptr: assert property (p_ptr) else $error("pointer not loaded");
	property p_nul; go && DM_READ_IN && !DM_ADDR_IN[7] && DM_ADDR_IN > 8'h08 && !SFR_PRESENT_IN
		|=> DM_RDATA_OUT == 8'h00; endproperty
	a_nul: assert property (p_nul) else $error("unused read not zero");
	c_busy: cover property (TABLE_BUSY_OUT);
	c_drive: cover property (!PROG_DATA_LINE_OE_N_OUT);
	c_dbg: cover property (DEBUG_MODE_IN && !SHARED_FUNC_ENABLE_OUT);
endmodule // prog_table_monitor
bind program_memory_table_read prog_table_monitor mon (.*);
`default_nettype wire

// ---- dv/core_model.sv ----
// processor core model that issues table lookups
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// bench command and block status
	input wire logic       clk_in, req_in, lp_in, busy_in,
	input wire logic [7:0] dst_in,
	// table request to the block
	output logic           rd_out, lp_out,
	output logic [7:0]     dst_out
);
	// idle before the first lookup
	initial begin
		rd_out = 1'b0;
		lp_out = 1'b0;
		dst_out = 8'h80;
	end
	// main flow only, interrupts held off, never while one is in flight
	always @(posedge clk_in) begin
		rd_out <= #1 req_in && !busy_in;
		lp_out <= #1 lp_in;
		dst_out <= #1 dst_in;
	end
endmodule // core_model
`default_nettype wire

// ---- dv/program_memory_table_read_tb.sv ----
// bench for the program store and table read block
`timescale 1ns/1ps
`default_nettype none
module program_memory_table_read_tb;
	logic        CLK_IN = 0, RESET_IN = 1, CLK_EN_IN = 1, PC_ADVANCE_IN = 0, PC_LOAD_IN = 0, sw;
	logic        DM_WRITE_IN = 0, DM_READ_IN = 0, SFR_PRESENT_IN = 0, SFR_PROTECTED_IN = 0;
	logic        DEBUG_MODE_IN = 0, PROG_ENABLE_IN = 0, PROG_CLOCK_LINE_IN = 0, drv = 0, req = 0, lp = 0;
	logic [10:0] PC_LOAD_VALUE_IN = 0;
	logic [7:0]  DM_ADDR_IN = 0, DM_WDATA_IN = 0, SFR_RDATA_IN = 0, dst = 0, rd;
	wire         PROG_DATA_LINE_IN, PROG_DATA_LINE_OUT, PROG_DATA_LINE_OE_N_OUT, SHARED_FUNC_ENABLE_OUT;
	wire         INSTR_VALID_OUT, TABLE_BUSY_OUT, SFR_WRITE_OUT, TABLE_READ_IN, TABLE_LAST_PAGE_IN;
	wire [10:0]  PC_OUT;
	wire [14:0]  INSTR_OUT;
	wire [7:0]   DM_RDATA_OUT, TABLE_POINTER_OUT, TABLE_DEST_IN;
	wire [6:0]   TABLE_HIGH_LATCH_OUT;
	int          failures = 0, checks_done = 0;
	// the line follows the device while its enable is low, else the programmer
	assign PROG_DATA_LINE_IN = PROG_DATA_LINE_OE_N_OUT ? drv : PROG_DATA_LINE_OUT;
	program_memory_table_read DUT (.*);
	core_model core (.clk_in(CLK_IN), .req_in(req), .lp_in(lp), .dst_in(dst), .busy_in(TABLE_BUSY_OUT),
		.rd_out(TABLE_READ_IN), .lp_out(TABLE_LAST_PAGE_IN), .dst_out(TABLE_DEST_IN));
	initial forever #2 CLK_IN = ~CLK_IN;
	////////////////////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(posedge CLK_IN);
		#1;
	endtask
	task chk(input string what, input logic [14:0] seen, input logic [14:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task finish_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one data access; the idle cycle after it keeps strobes from being reassigned at once
	task dm(input logic wr, input logic [7:0] a, input logic [7:0] d);
		DM_ADDR_IN = a;
		DM_WDATA_IN = d;
		DM_WRITE_IN = wr;
		DM_READ_IN = !wr;
		cyc(1);
		rd = DM_RDATA_OUT;
		sw = SFR_WRITE_OUT;
		DM_WRITE_IN = 0;
		DM_READ_IN = 0;
		cyc(1);
	endtask
	task pbit(input logic b);
		drv = b;
		PROG_CLOCK_LINE_IN = 0;
		cyc(3);
		PROG_CLOCK_LINE_IN = 1;
		cyc(3);
	endtask
	// serial frame, msb first; a read clocks the word back while the device drives the line
	task frame(input logic [1:0] cmd, input logic [10:0] a, input logic [14:0] d);
		logic [27:0] f;
		f = {cmd, a, d};
		PROG_ENABLE_IN = 1;
		for (int i = 27; i >= 0; i--) pbit(f[i]);
		for (int i = 14; i >= 0 && cmd == 2'h3; i--) begin
			pbit(~drv);
			chk("serial bit", 15'(PROG_DATA_LINE_IN), 15'(d[i]));
		end
		PROG_CLOCK_LINE_IN = 0;
		cyc(4);
		chk("fetch refused", 15'(INSTR_VALID_OUT), 15'h0000);
		PROG_ENABLE_IN = 0;
		cyc(2);
	endtask
	task pcload(input logic [10:0] v);
		PC_LOAD_VALUE_IN = v;
		PC_LOAD_IN = 1;
		cyc(1);
		PC_LOAD_IN = 0;
	endtask
	task t_fetch;
		pcload(11'h7FF);
		PC_ADVANCE_IN = 1;
		cyc(1);
		PC_ADVANCE_IN = 0;
		chk("last word", INSTR_OUT, 15'h4321);
		chk("fetch valid", 15'(INSTR_VALID_OUT), 15'h0001);
		chk("pc wrap", 15'(PC_OUT), 15'h0000);
	endtask
	task tread(input logic l, input logic [7:0] p, input logic [7:0] t, input logic [14:0] w);
		logic [10:0] pc;
		pc = PC_OUT;
		dm(1, 8'h07, p);
		chk("pointer", 15'(TABLE_POINTER_OUT), 15'(p));
		req = 1;
		lp = l;
		dst = t;
		cyc(1);
		req = 0;
		cyc(1);
		chk("busy", 15'(TABLE_BUSY_OUT), 15'h0001);
		cyc(1);
		chk("busy end", 15'(TABLE_BUSY_OUT), 15'h0000);
		chk("high part", 15'(TABLE_HIGH_LATCH_OUT), 15'(w[14:8]));
		chk("pc held", 15'(PC_OUT), 15'(pc));
		dm(0, t, 8'h00);
		chk("low byte", 15'(rd), 15'(w[7:0]));
	endtask
	task t_dm;
		dm(1, 8'h08, 8'h00);
		chk("latch kept", 15'(TABLE_HIGH_LATCH_OUT), 15'h0043);
		dm(1, 8'h80, 8'hA5);
		dm(0, 8'h80, 8'h00);
		chk("gpr", 15'(rd), 15'h00A5);
		dm(0, 8'h7F, 8'h00);
		chk("unused sfr", 15'(rd), 15'h0000);
		SFR_PROTECTED_IN = 1;
		dm(1, 8'h20, 8'h11);
		chk("protected", 15'(sw), 15'h0000);
		SFR_PROTECTED_IN = 0;
		SFR_PRESENT_IN = 1;
		SFR_RDATA_IN = 8'h5C;
		dm(1, 8'h20, 8'h11);
		chk("open sfr", 15'(sw), 15'h0001);
		dm(0, 8'h20, 8'h00);
		chk("sfr area", 15'(rd), 15'h005C);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		failures++;
		finish_test;
	end
	initial begin
		cyc(2);
		RESET_IN = 0;
		chk("reset line", 15'(PROG_DATA_LINE_OE_N_OUT), 15'h0001);
		frame(2'h2, 11'h706, 15'h5A1A);
		frame(2'h2, 11'h105, 15'h0F0F);
		frame(2'h2, 11'h7FF, 15'h4321);
		t_fetch;
		pcload(11'h1F0);
		tread(0, 8'h05, 8'hFF, 15'h0F0F);
		tread(1, 8'h06, 8'h80, 15'h5A1A);
		tread(1, 8'hFF, 8'h81, 15'h4321);
		t_dm;
		DEBUG_MODE_IN = 1;
		frame(2'h3, 11'h706, 15'h5A1A);
		DEBUG_MODE_IN = 0;
		RESET_IN = 1;
		cyc(2);
		RESET_IN = 0;
		cyc(1);
		chk("vector", 15'(PC_OUT), 15'h0000);
		finish_test;
	end
endmodule // program_memory_table_read_tb
`default_nettype wire
